// ==== soft_limit_defines.svh ====
`ifndef SOFT_LIMIT_DEFINES_SVH
`define SOFT_LIMIT_DEFINES_SVH

// ==========================================================
// setting digits and field positions
`define ENABLE_DIGIT_LSB 0
`define CHECK_DIGIT_LSB 8
`define LIMIT_BOTH 4'h0
`define LIMIT_FWD_ONLY 4'h1
`define LIMIT_REV_ONLY 4'h2
`define LIMIT_NONE 4'h3
`define CHECK_ON 4'h1
`define WARN_DETECT 4'h1

// ==========================================================
// limit values (documented defaults, reference units)
`define FWD_LIMIT_DEFAULT 32'h3fffffff
`define REV_LIMIT_DEFAULT 32'hc0000001

// ==========================================================
// timing
`define REF_CLK_KHZ 25000
`define DELAY_UNIT_MS 10
`define DELAY_UNIT_CYCLES (`DELAY_UNIT_MS * `REF_CLK_KHZ)
`define DELAY_MAX_UNITS 6'h32
`define TICK_WIDTH 18

`endif

// ==== soft_limit_pkg.sv ====
package soft_limit_pkg;

  typedef logic signed [31:0] position_type;

  // host commands, all one-cycle strobes except the flag and target
  typedef struct packed {
    logic servo_power_on_cmd;
    logic servo_power_off_cmd;
    logic homing_cmd;
    logic position_set;
    logic reference_point_valid;
    logic positioning_cmd;
    logic interpolation_cmd;
    position_type target;
  } cmd_type;

  typedef enum logic [2:0] {
    PH_OFF = 3'b001,
    PH_RUN = 3'b010,
    PH_DELAY = 3'b100
  } phase_type;

  typedef struct packed {
    logic fwd_meta;
    logic fwd_sync;
    logic rev_meta;
    logic rev_sync;
    logic ref_valid;
    logic warn;
    phase_type phase;
    logic brake;
    logic power;
    logic estop;
    logic decel;
    logic move_valid;
    position_type stop_pos;
  } state_type;

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] units;
    logic [17:0] ticks;
  } timer_state_type;

endpackage

// ==== brake_delay_timer.sv ====
`timescale 1ns/1ps
`include "soft_limit_defines.svh"

module brake_delay_timer #(
  parameter int UNIT_CYCLES = `DELAY_UNIT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // control
  input wire logic start,
  input wire logic [5:0] units,
  output logic done
);
  import soft_limit_pkg::*;

  if (UNIT_CYCLES < 1 || UNIT_CYCLES > (1 << `TICK_WIDTH)) begin : g_bad_unit
    $error("UNIT_CYCLES out of range");
  end

  localparam logic [17:0] TICK_LAST = 18'(UNIT_CYCLES - 1);

  timer_state_type s_q;
  timer_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.busy = (units != 6'h0);
      s_d.done = (units == 6'h0);
      s_d.units = units;
      s_d.ticks = TICK_LAST;
    end else if (s_q.busy) begin
      if (s_q.ticks != 18'h0) begin
        s_d.ticks = s_q.ticks - 18'h1;
      end else if (s_q.units == 6'h1) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.units = s_q.units - 6'h1;
        s_d.ticks = TICK_LAST;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;

  chk_done_after_busy: assert property (@(posedge ref_clk) disable iff (srst)
    (clk_en && s_q.done) |-> !s_q.busy) else $error("timer done while busy");
endmodule

// ==== soft_limit_and_brake_timing.sv ====
`timescale 1ns/1ps
`include "soft_limit_defines.svh"

module soft_limit_and_brake_timing #(
  parameter int UNIT_CYCLES = `DELAY_UNIT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // settings
  input wire logic [3:0] travel_warning_select,
  input wire logic [15:0] soft_limit_control,
  input wire soft_limit_pkg::position_type forward_position_limit,
  input wire soft_limit_pkg::position_type reverse_position_limit,
  input wire logic [5:0] brake_to_power_off_delay,
  // host commands
  input wire soft_limit_pkg::cmd_type cmd,
  input wire logic warning_clear,
  // drive status
  input wire logic alarm,
  input wire soft_limit_pkg::position_type feedback_position,
  // pins, high while run allowed
  input wire logic forward_travel_block,
  input wire logic reverse_travel_block,
  // outputs
  output logic brake_release_out,
  output logic motor_power_on,
  output logic emergency_stop,
  output logic overtravel_warning,
  output logic reference_established,
  output logic move_valid,
  output logic decel_stop,
  output soft_limit_pkg::position_type stop_position
);
  import soft_limit_pkg::*;

  if (UNIT_CYCLES < 1) begin : g_bad_unit
    $error("UNIT_CYCLES must be positive");
  end

  // ==========================================================
  // helpers
  function automatic logic outside(input position_type pos, input position_type fwd,
                                   input position_type rev, input logic fen, input logic ren);
    outside = (fen && (pos > fwd)) || (ren && (pos < rev));
  endfunction

  state_type s_q;
  state_type s_d;
  logic [3:0] en_digit;
  logic [3:0] chk_digit;
  logic warn_en;
  logic fen;
  logic ren;
  logic hw_ot;
  logic soft_ot;
  logic timer_start;
  logic timer_done;
  logic move;

  assign en_digit = soft_limit_control[`ENABLE_DIGIT_LSB +: 4];
  assign chk_digit = soft_limit_control[`CHECK_DIGIT_LSB +: 4];
  assign warn_en = (travel_warning_select == `WARN_DETECT);
  // settings act combinationally so a change takes hold at once
  assign fen = s_q.ref_valid
               && ((en_digit == `LIMIT_BOTH) || (en_digit == `LIMIT_FWD_ONLY));
  assign ren = s_q.ref_valid
               && ((en_digit == `LIMIT_BOTH) || (en_digit == `LIMIT_REV_ONLY));
  assign hw_ot = !s_q.fwd_sync || !s_q.rev_sync;
  assign soft_ot = outside(feedback_position, forward_position_limit,
                           reverse_position_limit, fen, ren);
  assign move = cmd.positioning_cmd || cmd.interpolation_cmd;

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    timer_start = 1'b0;
    s_d.fwd_meta = forward_travel_block;
    s_d.fwd_sync = s_q.fwd_meta;
    s_d.rev_meta = reverse_travel_block;
    s_d.rev_sync = s_q.rev_meta;

    if (cmd.homing_cmd) begin
      s_d.ref_valid = 1'b1;
    end else if (cmd.position_set) begin
      s_d.ref_valid = cmd.reference_point_valid;
    end

    // same stop path as the hardware inputs
    s_d.estop = s_q.power && (hw_ot || soft_ot);

    // sticky; a fresh detection beats a clear in the same cycle
    s_d.warn = (warn_en && s_q.power && (hw_ot || soft_ot))
               || (s_q.warn && !warning_clear);

    // warning state is not consulted here on purpose
    s_d.move_valid = move;
    s_d.decel = 1'b0;
    if (move) begin
      s_d.stop_pos = cmd.target;
      if ((chk_digit == `CHECK_ON) && outside(cmd.target, forward_position_limit,
                                              reverse_position_limit, fen, ren)) begin
        s_d.decel = 1'b1;
        s_d.stop_pos = (cmd.target > forward_position_limit) ?
                       forward_position_limit : reverse_position_limit;
      end
    end

    case (s_q.phase)
      PH_OFF: begin
        if (cmd.servo_power_on_cmd && !alarm) begin
          s_d.phase = PH_RUN;
          s_d.power = 1'b1;
          s_d.brake = 1'b1;
        end
      end
      PH_RUN: begin
        if (alarm) begin
          s_d.phase = PH_OFF;
          s_d.power = 1'b0;
          s_d.brake = 1'b0;
        end else if (cmd.servo_power_off_cmd) begin
          s_d.brake = 1'b0;
          if (brake_to_power_off_delay == 6'h0) begin
            s_d.phase = PH_OFF;
            s_d.power = 1'b0;
          end else begin
            s_d.phase = PH_DELAY;
            timer_start = 1'b1;
          end
        end
      end
      PH_DELAY: begin
        // alarm cuts power without waiting for the hold time
        if (alarm || timer_done) begin
          s_d.phase = PH_OFF;
          s_d.power = 1'b0;
        end
      end
      default: begin
        s_d.phase = PH_OFF;
        s_d.power = 1'b0;
        s_d.brake = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '{fwd_meta: 1'b1, fwd_sync: 1'b1, rev_meta: 1'b1, rev_sync: 1'b1,
               ref_valid: 1'b0, warn: 1'b0, phase: PH_OFF, brake: 1'b0, power: 1'b0,
               estop: 1'b0, decel: 1'b0, move_valid: 1'b0, stop_pos: 32'h0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // power-off hold timer
  brake_delay_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_hold (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .start(timer_start),
    .units((brake_to_power_off_delay > `DELAY_MAX_UNITS) ?
           `DELAY_MAX_UNITS : brake_to_power_off_delay),
    .done(timer_done)
  );

  assign brake_release_out = s_q.brake;
  assign motor_power_on = s_q.power;
  assign emergency_stop = s_q.estop;
  assign overtravel_warning = s_q.warn;
  assign reference_established = s_q.ref_valid;
  assign move_valid = s_q.move_valid;
  assign decel_stop = s_q.decel;
  assign stop_position = s_q.stop_pos;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence off_taken;
    clk_en && s_q.phase == PH_RUN && cmd.servo_power_off_cmd && !alarm
      && brake_to_power_off_delay != 6'h0;
  endsequence

  sequence on_taken;
    clk_en && s_q.phase == PH_OFF && cmd.servo_power_on_cmd && !alarm;
  endsequence

  chk_warn_gate: assert property ((clk_en && !s_q.warn && !warn_en) |=> !overtravel_warning)
    else $error("warning raised while disabled");
  chk_warn_passive: assert property ((clk_en && move && s_q.warn) |=> move_valid)
    else $error("command dropped under warning");
  chk_soft_estop: assert property ((clk_en && s_q.power && soft_ot) |=> emergency_stop)
    else $error("soft limit crossing without stop");
  chk_unarmed_quiet: assert property ((clk_en && !s_q.ref_valid && !hw_ot) |=> !emergency_stop)
    else $error("stop without established reference");
  chk_digit_none: assert property ((clk_en && en_digit == `LIMIT_NONE && !hw_ot) |=> !emergency_stop)
    else $error("stop with limits disabled");
  chk_target_clamp: assert property ((clk_en && move && chk_digit == `CHECK_ON && fen
    && cmd.target > forward_position_limit) |=> decel_stop
    && stop_position == $past(forward_position_limit))
    else $error("far target not clamped");
  chk_brake_on: assert property (on_taken |=> brake_release_out && motor_power_on)
    else $error("brake not released at servo on");
  chk_alarm_brake: assert property ((clk_en && alarm) |=> !brake_release_out)
    else $error("brake held open under alarm");
  chk_power_hold: assert property (off_taken |=> !brake_release_out && motor_power_on [*2])
    else $error("power dropped before hold time");
  chk_soft_warn: assert property ((clk_en && warn_en && s_q.power && soft_ot) |=> overtravel_warning)
    else $error("soft crossing not warned");
  chk_limit_edge: assert property ((clk_en && fen && !ren && !hw_ot
    && feedback_position == forward_position_limit) |=> !emergency_stop)
    else $error("stop at exact limit value");
endmodule

// ==== host_model.sv ====
`timescale 1ns/1ps
module host_model #(
  parameter int RELEASE_CYCLES = 3,
  parameter int GUARD_CYCLES = 2
) (
  // clock
  input wire logic ref_clk,
  // toward the drive
  output soft_limit_pkg::cmd_type cmd,
  output soft_limit_pkg::position_type fwd_lim,
  output soft_limit_pkg::position_type rev_lim
);
  import soft_limit_pkg::*;
  int cycles = 0;
  int on_at = 0;
  initial begin
    cmd = '0;
    fwd_lim = 32'sh00000100;
    rev_lim = -32'sh00000100;
  end
  always @(posedge ref_clk) cycles <= cycles + 1;
  // idle target inverted so a stale value never looks fresh
  task automatic pulse(input cmd_type c);
    cmd_type idle;
    idle = '0;
    idle.target = ~c.target;
    @(posedge ref_clk);
    cmd <= c;
    @(posedge ref_clk);
    cmd <= idle;
  endtask
  // kind: 0 on, 1 off, 2 homing done, 3 set unmarked, 4 set marked
  task automatic op(input int kind);
    cmd_type c;
    c = '0;
    c.servo_power_on_cmd = (kind == 0);
    c.servo_power_off_cmd = (kind == 1);
    c.homing_cmd = (kind == 2);
    c.position_set = (kind >= 3);
    c.reference_point_valid = (kind == 4);
    pulse(c);
    if (kind == 0) on_at = cycles;
  endtask
  task automatic move(input logic interp, input position_type tgt);
    cmd_type c;
    c = '0;
    while (cycles - on_at < RELEASE_CYCLES + GUARD_CYCLES) @(posedge ref_clk);
    c.positioning_cmd = !interp;
    c.interpolation_cmd = interp;
    c.target = tgt;
    pulse(c);
  endtask
  task automatic set_limits(input position_type f, input position_type r);
    @(posedge ref_clk);
    if (r < f) begin
      fwd_lim <= f;
      rev_lim <= r;
    end
  endtask
endmodule

// ==== soft_limit_and_brake_timing_bench.sv ====
`timescale 1ns/1ps
module soft_limit_and_brake_timing_bench;
  import soft_limit_pkg::*;
  localparam int UNIT = 4;
  logic ref_clk = 1'b0;
  logic srst;
  logic clk_en;
  logic [3:0] travel_warning_select;
  logic [15:0] soft_limit_control;
  logic [5:0] brake_to_power_off_delay;
  logic warning_clear;
  logic alarm;
  position_type feedback_position;
  logic forward_travel_block;
  logic reverse_travel_block;
  cmd_type cmd;
  position_type fwd_lim;
  position_type rev_lim;
  logic brake_release_out;
  logic motor_power_on;
  logic emergency_stop;
  logic overtravel_warning;
  logic reference_established;
  logic move_valid;
  logic decel_stop;
  position_type stop_position;
  int err_total = 0;
  int checked = 0;
  int cycles_run = 0;

  // ==========================================
  // clock, parts
  initial forever #20 ref_clk = ~ref_clk;
  host_model i_host_model (.ref_clk(ref_clk), .cmd(cmd), .fwd_lim(fwd_lim), .rev_lim(rev_lim));
  soft_limit_and_brake_timing #(.UNIT_CYCLES(UNIT)) i_soft_limit_and_brake_timing (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .travel_warning_select(travel_warning_select), .soft_limit_control(soft_limit_control),
    .forward_position_limit(fwd_lim), .reverse_position_limit(rev_lim),
    .brake_to_power_off_delay(brake_to_power_off_delay), .cmd(cmd),
    .warning_clear(warning_clear), .alarm(alarm), .feedback_position(feedback_position),
    .forward_travel_block(forward_travel_block), .reverse_travel_block(reverse_travel_block),
    .brake_release_out(brake_release_out), .motor_power_on(motor_power_on),
    .emergency_stop(emergency_stop), .overtravel_warning(overtravel_warning),
    .reference_established(reference_established), .move_valid(move_valid),
    .decel_stop(decel_stop), .stop_position(stop_position));

  // ==========================================
  // helpers
  task automatic print_verdict();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic probe(input logic [3:0] d, input position_type p, input logic e);
    @(posedge ref_clk);
    soft_limit_control <= {12'h000, d};
    feedback_position <= p;
    repeat (2) @(posedge ref_clk);
    #1 check("estop", e, emergency_stop);
  endtask
  task automatic mv(input logic i, input position_type t, input logic dc, input position_type sp);
    i_host_model.move(i, t);
    #1 check("move_valid", 1'b1, move_valid);
    check("decel", dc, decel_stop);
    check("stop_pos", sp, stop_position);
  endtask

  // ==========================================
  // scenarios
  task automatic t_brake();
    i_host_model.op(0);
    #1 check("on", 2'b11, {brake_release_out, motor_power_on});
    i_host_model.op(1);
    #1 check("off_now", 2'b00, {brake_release_out, motor_power_on});
    @(posedge ref_clk) brake_to_power_off_delay <= 6'h02;
    i_host_model.op(0);
    i_host_model.op(1);
    #1 check("hold", 2'b01, {brake_release_out, motor_power_on});
    repeat (2 * UNIT) @(posedge ref_clk);
    #1 check("hold_mid", 1'b1, motor_power_on);
    @(posedge ref_clk);
    #1 check("hold_end", 1'b0, motor_power_on);
    i_host_model.op(0);
    @(posedge ref_clk) alarm <= 1'b1;
    @(posedge ref_clk) alarm <= 1'b0;
    #1 check("alarm", 2'b00, {brake_release_out, motor_power_on});
  endtask
  task automatic t_limits();
    i_host_model.op(0);
    probe(4'h0, 32'sh101, 1'b0);
    i_host_model.op(4);
    #1 check("ref_marked", 1'b1, reference_established);
    i_host_model.op(3);
    #1 check("ref_unmarked", 1'b0, reference_established);
    i_host_model.op(4);
    #1 check("ref_remarked", 1'b1, reference_established);
    @(posedge ref_clk) srst <= 1'b1;
    @(posedge ref_clk) srst <= 1'b0;
    #1 check("ref_reset", 1'b0, reference_established);
    i_host_model.op(2);
    #1 check("ref_homed", 1'b1, reference_established);
    i_host_model.op(0);
    for (int d = 0; d < 4; d++) begin
      probe(d[3:0], 32'sh100, 1'b0);
      probe(d[3:0], 32'sh101, d < 2);
      probe(d[3:0], -32'sh101, d == 0 || d == 2);
    end
    check("warn_off", 1'b0, overtravel_warning);
    probe(4'h0, 32'sh101, 1'b1);
    @(posedge ref_clk) travel_warning_select <= 4'h1;
    repeat (2) @(posedge ref_clk);
    #1 check("warn_on", 1'b1, overtravel_warning);
    probe(4'h0, 32'sh0, 1'b0);
    mv(1'b0, 32'sh50, 1'b0, 32'sh50);
    @(posedge ref_clk) warning_clear <= 1'b1;
    @(posedge ref_clk) warning_clear <= 1'b0;
    #1 check("warn_clr", 1'b0, overtravel_warning);
    @(posedge ref_clk) forward_travel_block <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check("pin_stop", 1'b1, emergency_stop);
    @(posedge ref_clk) forward_travel_block <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 check("pin_clear", 1'b0, emergency_stop);
    @(posedge ref_clk) reverse_travel_block <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check("pin_rev", 1'b1, emergency_stop);
    @(posedge ref_clk) reverse_travel_block <= 1'b1;
  endtask
  task automatic t_move();
    @(posedge ref_clk) soft_limit_control <= 16'h0100;
    mv(1'b0, 32'sh105, 1'b1, 32'sh100);
    mv(1'b1, -32'sh105, 1'b1, -32'sh100);
    mv(1'b0, 32'sh50, 1'b0, 32'sh50);
    @(posedge ref_clk) soft_limit_control <= 16'h0000;
    mv(1'b1, 32'sh105, 1'b0, 32'sh105);
    @(posedge ref_clk) soft_limit_control <= 16'h0100;
    i_host_model.set_limits(32'sh200, -32'sh100);
    mv(1'b0, 32'sh180, 1'b0, 32'sh180);
  endtask
  // a servo-off while frozen must be lost, the next one taken
  task automatic t_freeze();
    @(posedge ref_clk) clk_en <= 1'b0;
    i_host_model.op(1);
    #1 check("frozen", 2'b11, {brake_release_out, motor_power_on});
    @(posedge ref_clk) clk_en <= 1'b1;
    i_host_model.op(1);
    #1 check("thawed", 2'b01, {brake_release_out, motor_power_on});
  endtask

  // ==========================================
  // main sequence and hang guard
  always @(posedge ref_clk) begin
    cycles_run <= cycles_run + 1;
    if (cycles_run == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    srst <= 1'b1;
    clk_en <= 1'b1;
    travel_warning_select <= 4'h0;
    soft_limit_control <= 16'h0003;
    brake_to_power_off_delay <= 6'h00;
    warning_clear <= 1'b0;
    alarm <= 1'b0;
    feedback_position <= 32'sh0;
    forward_travel_block <= 1'b1;
    reverse_travel_block <= 1'b1;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    #1 check("reset", 5'h00, {brake_release_out, motor_power_on, emergency_stop,
      overtravel_warning, reference_established});
    t_brake();
    t_limits();
    t_move();
    t_freeze();
    print_verdict();
  end
endmodule
